// ### logic/cfgrb_pkg.sv
// Purpose: Shared constants and types for the configuration readback block
// Assumes: 32-bit classic Wishbone slave, 50 MHz system clock
// Notes: Offsets are byte addresses, one aligned word per register
`default_nettype none
package cfgrb_pkg;
   // Register offsets
   localparam logic [7:0] CFGRB_CTRL_OFS = 8'h00;
   localparam logic [7:0] CFGRB_STATUS_OFS = 8'h04;
   localparam logic [7:0] CFGRB_FIDX_OFS = 8'h08;
   localparam logic [7:0] CFGRB_FDATA_OFS = 8'h0c;
   localparam logic [7:0] CFGRB_CRC_OFS = 8'h10;
   localparam logic [7:0] CFGRB_CAPT_OFS = 8'h14;
   // Control field positions and reset value
   localparam int CFGRB_CTRL_ABORT_BIT = 0;
   localparam int CFGRB_CTRL_CAPT_BIT = 1;
   localparam int CFGRB_CTRL_UCLK_BIT = 2;
   localparam int CFGRB_CTRL_W = 3;
   localparam logic [2:0] CFGRB_CTRL_RESET = 3'h0;
   // Status field positions
   localparam int CFGRB_ST_RIP_BIT = 0;
   localparam int CFGRB_ST_LOAD_BIT = 1;
   localparam int CFGRB_ST_PHERR_BIT = 2;
   localparam int CFGRB_ST_REINIT_BIT = 3;
   localparam int CFGRB_ST_STATE_LSB = 4;
   localparam int CFGRB_ST_FRAME_LSB = 8;
   // Stream layout
   localparam int CFGRB_DUMMY_BITS = 5;
   localparam int CFGRB_FIRST_HIGH_BITS = 2;
   localparam int CFGRB_CHECK_BITS = 4;
   localparam int CFGRB_LAST_HIGH_BITS = 7;
   localparam int CFGRB_CRC_BITS = 11;
   localparam int CFGRB_LOAD_CYCLES = 6;
   localparam logic [10:0] CFGRB_CRC_POLY = 11'h005;
   localparam logic [10:0] CFGRB_CRC_INIT = 11'h000;
   // Readback clock phase limits while the shift register loads
   localparam int CFGRB_CLK_PERIOD_NS = 20;
   localparam int CFGRB_PHASE_MIN_NS = 250;
   localparam int CFGRB_PHASE_MAX_NS = 500;
   localparam int CFGRB_PHASE_MIN_CYC =
      (CFGRB_PHASE_MIN_NS + CFGRB_CLK_PERIOD_NS - 1) / CFGRB_CLK_PERIOD_NS;
   localparam int CFGRB_PHASE_MAX_CYC =
      CFGRB_PHASE_MAX_NS / CFGRB_CLK_PERIOD_NS;
   // Stream sequencer, Gray codes along the usual path except CHECK back to START
   typedef enum logic [2:0] {
      CFGRB_IDLE = 3'h0,
      CFGRB_DUMMY = 3'h1,
      CFGRB_START = 3'h3,
      CFGRB_DATA = 3'h2,
      CFGRB_CHECK = 3'h6,
      CFGRB_CRCST = 3'h7,
      CFGRB_CRC = 3'h5,
      CFGRB_REINIT = 3'h4
   } cfgrb_state_t;
endpackage
`default_nettype wire

// ### logic/cfgrb_pin_sync.sv
// Purpose: Two-flop synchroniser with edge detection for one pin
// Assumes: Pin is asynchronous to clk_sys
// Notes: Edges come from the second and third flops only
`timescale 1ns/10ps
`default_nettype none
module cfgrb_pin_sync
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic pinIn,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // First flop feeds only the second
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         meta_reg <= pinIn;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Edge pulses last one enabled cycle
   assign level = sync_reg;
   assign rise = clkEn & sync_reg & ~prev_reg;
   assign fall = clkEn & ~sync_reg & prev_reg;
endmodule // cfgrb_pin_sync
`default_nettype wire

// ### logic/cfgrb_readback_ctrl.sv
// Purpose: Serial readback of frame memory and captured state
// Assumes: Trigger and readback clocks are pins, sampled on clk_sys
// Notes: Registers on classic Wishbone, one-wait-state answer
// How it works
// - Abort option: trigger fall ends readback
// - Progress flag high exactly during readback
// - Configuration clock unless user clock selected
// - State and data advance on readback rises
// - Next frame loads in six-cycle window
// - Trigger high at finish starts readback
// - Progress rises next clock; then one bit/edge
// - Five high dummies, low start, two highs
// - Four high checks; start, CRC, then end
// - Capture samples inverted state on trigger
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cfgrb_readback_ctrl
#(
   parameter int FRAME_W = 32,
   parameter int NUM_FRAMES = 4,
   parameter int CAPT_FRAME = 1
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic readback_trigger,
   input wire logic configuration_clock,
   input wire logic userReadbackClock,
   input wire logic startupFinished,
   input wire logic [FRAME_W-1:0] captureIn,
   output logic readbackData,
   output logic read_in_progress
);
   localparam int FIW = (NUM_FRAMES > 1) ? $clog2(NUM_FRAMES) : 1;
   localparam int BCW = $clog2(FRAME_W + 16);
   localparam int CRCW = cfgrb_pkg::CFGRB_CRC_BITS;

   // Merge write data into a word under byte enables
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] wdat, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            res[i*8 +: 8] = wdat[i*8 +: 8];
      end
      return res;
   endfunction

   // One step of the signature over a sent data bit
   function automatic logic [CRCW-1:0] crcStep(input logic [CRCW-1:0] c,
      input logic b);
      logic fb;
      fb = c[CRCW-1] ^ b;
      return {c[CRCW-2:0], 1'b0} ^ (fb ? cfgrb_pkg::CFGRB_CRC_POLY :
         cfgrb_pkg::CFGRB_CRC_INIT);
   endfunction

   logic [FRAME_W-1:0] frameMem_reg [NUM_FRAMES];
   logic [FRAME_W-1:0] captureReg_reg;
   logic [cfgrb_pkg::CFGRB_CTRL_W-1:0] ctrl_reg;
   logic [FIW-1:0] fidx_reg;
   cfgrb_pkg::cfgrb_state_t state_reg;
   logic [BCW-1:0] bitCnt_reg;
   logic [FIW-1:0] frame_reg;
   logic [FRAME_W-1:0] shift_reg;
   logic [FRAME_W-1:0] stage_reg;
   logic [CRCW-1:0] crc_reg;
   logic [CRCW-1:0] crcOut_reg;
   logic [CRCW-1:0] crcLast_reg;
   logic startPend_reg;
   logic abortPend_reg;
   logic finPrev_reg;
   logic phErr_reg;
   logic [5:0] phCnt_reg;
   logic ack_reg;
   logic [31:0] rdat_reg;

   // Frame word as it leaves the device
   function automatic logic [FRAME_W-1:0] frameWord(input logic [FIW-1:0] i,
      input logic [FRAME_W-1:0] mem, input logic [FRAME_W-1:0] capt,
      input logic captEn);
      logic [FRAME_W-1:0] w;
      w = (captEn && int'(i) == CAPT_FRAME) ? capt : mem;
      if (int'(i) == 0)
         w[FRAME_W-1 -: cfgrb_pkg::CFGRB_FIRST_HIGH_BITS] = '1;
      if (int'(i) == NUM_FRAMES - 1)
         w[cfgrb_pkg::CFGRB_LAST_HIGH_BITS-1:0] = '1;
      return w;
   endfunction

   // Pin synchronisers
   logic trigLevel, trigRise, trigFall;
   logic cfgRise, cfgFall;
   logic usrRise, usrFall;

   cfgrb_pin_sync trigSync
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .clkEn(clkEn),
      .pinIn(readback_trigger),
      .level(trigLevel),
      .rise(trigRise),
      .fall(trigFall)
   );

   cfgrb_pin_sync cfgClkSync
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .clkEn(clkEn),
      .pinIn(configuration_clock),
      .level(),
      .rise(cfgRise),
      .fall(cfgFall)
   );

   cfgrb_pin_sync usrClkSync
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .clkEn(clkEn),
      .pinIn(userReadbackClock),
      .level(),
      .rise(usrRise),
      .fall(usrFall)
   );

   // Clock select and event decode
   wire abortEn = ctrl_reg[cfgrb_pkg::CFGRB_CTRL_ABORT_BIT];
   wire captEn = ctrl_reg[cfgrb_pkg::CFGRB_CTRL_CAPT_BIT];
   wire userSel = ctrl_reg[cfgrb_pkg::CFGRB_CTRL_UCLK_BIT];
   wire rdClkRise = userSel ? usrRise : cfgRise;
   wire rdClkEdge = userSel ? (usrRise | usrFall) : (cfgRise | cfgFall);
   wire idle = (state_reg == cfgrb_pkg::CFGRB_IDLE);
   wire finRise = clkEn & startupFinished & ~finPrev_reg;
   // Trigger rises before start-up finishes are not taken; the finish
   // itself then starts the first readback if the trigger is high
   wire startReq = idle & ~startPend_reg & startupFinished &
      (trigRise | (finRise & trigLevel));
   wire abortReq = abortEn & trigFall & read_in_progress;
   wire lastFrame = (int'(frame_reg) == NUM_FRAMES - 1);
   wire lastData = (bitCnt_reg == BCW'(FRAME_W - 1));
   wire lastCheck = (bitCnt_reg == BCW'(cfgrb_pkg::CFGRB_CHECK_BITS - 1));
   wire [FIW-1:0] nextFrame = frame_reg + FIW'(1);
   wire [FRAME_W-1:0] word0 = frameWord(FIW'(0), frameMem_reg[0],
      captureReg_reg, captEn);
   wire [FRAME_W-1:0] wordNext = frameWord(nextFrame,
      frameMem_reg[nextFrame], captureReg_reg, captEn);

   // Six edges up to and including each start bit
   wire loadWindow = (state_reg == cfgrb_pkg::CFGRB_DUMMY) |
      (state_reg == cfgrb_pkg::CFGRB_START) |
      (state_reg == cfgrb_pkg::CFGRB_CRCST) |
      (state_reg == cfgrb_pkg::CFGRB_CHECK) |
      ((state_reg == cfgrb_pkg::CFGRB_DATA) & lastData);

   // Wishbone decode
   wire wbReq = wb_cyc_i & wb_stb_i;
   wire wbWr = wbReq & wb_we_i & ack_reg & clkEn;
   wire selCtrl = (wb_adr_i == cfgrb_pkg::CFGRB_CTRL_OFS);
   wire selStat = (wb_adr_i == cfgrb_pkg::CFGRB_STATUS_OFS);
   wire selFidx = (wb_adr_i == cfgrb_pkg::CFGRB_FIDX_OFS);
   wire selFdat = (wb_adr_i == cfgrb_pkg::CFGRB_FDATA_OFS);
   wire selCrc = (wb_adr_i == cfgrb_pkg::CFGRB_CRC_OFS);
   wire selCapt = (wb_adr_i == cfgrb_pkg::CFGRB_CAPT_OFS);
   wire [31:0] ctrlWide = {{(32 - cfgrb_pkg::CFGRB_CTRL_W){1'b0}}, ctrl_reg};
   wire [31:0] ctrlMerged = mergeBytes(ctrlWide, wb_dat_i, wb_sel_i);
   wire [31:0] fdatWide = 32'(frameMem_reg[fidx_reg]);
   wire [31:0] fdatMerged = mergeBytes(fdatWide, wb_dat_i, wb_sel_i);
   wire phClr = wbWr & selStat & wb_sel_i[0] &
      wb_dat_i[cfgrb_pkg::CFGRB_ST_PHERR_BIT];
   wire phBad = rdClkEdge & read_in_progress & loadWindow &
      ((int'(phCnt_reg) < cfgrb_pkg::CFGRB_PHASE_MIN_CYC - 1) |
      (int'(phCnt_reg) > cfgrb_pkg::CFGRB_PHASE_MAX_CYC));

   // Status word; sampling jitter of one cycle is tolerated
   wire [31:0] statusWord = 32'({frame_reg, 1'b0, state_reg,
      (state_reg == cfgrb_pkg::CFGRB_REINIT), phErr_reg, loadWindow,
      read_in_progress});

   wire [31:0] readMux = selCtrl ? ctrlWide :
      selStat ? statusWord :
      selFidx ? 32'(fidx_reg) :
      selFdat ? fdatWide :
      selCrc ? 32'(crcLast_reg) :
      selCapt ? 32'(captureReg_reg) : 32'h0000_0000;

   // Bus slave: ack one cycle after request, write on ack edge
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end
      else if (clkEn)
      begin
         ack_reg <= wbReq & ~ack_reg;
         if (wbReq & ~ack_reg)
            rdat_reg <= readMux;
      end
   end

   // Software-written control and frame index
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         ctrl_reg <= cfgrb_pkg::CFGRB_CTRL_RESET;
         fidx_reg <= '0;
      end
      else if (wbWr & selCtrl)
         ctrl_reg <= ctrlMerged[cfgrb_pkg::CFGRB_CTRL_W-1:0];
      else if (wbWr & selFidx & wb_sel_i[0])
         fidx_reg <= wb_dat_i[FIW-1:0];
   end

   // Frame storage; no reset, software fills it before readback
   always_ff @(posedge clk_sys)
   begin
      if (wbWr & selFdat)
         frameMem_reg[fidx_reg] <= fdatMerged[FRAME_W-1:0];
   end

   // Trigger bookkeeping in the system domain
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         startPend_reg <= 1'b0;
         abortPend_reg <= 1'b0;
         finPrev_reg <= 1'b0;
         captureReg_reg <= '0;
      end
      else if (clkEn)
      begin
         finPrev_reg <= startupFinished;
         if (startReq)
            startPend_reg <= 1'b1;
         else if (rdClkRise & idle)
            startPend_reg <= 1'b0;
         else if (abortEn & trigFall)
            startPend_reg <= 1'b0;
         if (startReq & captEn)
            captureReg_reg <= ~captureIn;
         if (abortReq)
            abortPend_reg <= 1'b1;
         else if (rdClkRise)
            abortPend_reg <= 1'b0;
      end
   end

   // Phase monitor; a new error wins over a clear
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         phCnt_reg <= 6'h00;
         phErr_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         if (rdClkEdge)
            phCnt_reg <= 6'h01;
         else if (phCnt_reg != 6'h3f)
            phCnt_reg <= phCnt_reg + 6'h01;
         if (phBad)
            phErr_reg <= 1'b1;
         else if (phClr)
            phErr_reg <= 1'b0;
      end
   end

   // Stream sequencer; moves only on selected readback clock rises
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state_reg <= cfgrb_pkg::CFGRB_IDLE;
         read_in_progress <= 1'b0;
         readbackData <= 1'b1;
         bitCnt_reg <= '0;
         frame_reg <= '0;
         shift_reg <= '0;
         stage_reg <= '0;
         crc_reg <= cfgrb_pkg::CFGRB_CRC_INIT;
         crcOut_reg <= cfgrb_pkg::CFGRB_CRC_INIT;
         crcLast_reg <= cfgrb_pkg::CFGRB_CRC_INIT;
      end
      else if (clkEn & rdClkRise)
      begin
         if (abortPend_reg & read_in_progress)
         begin
            // Recovery edge before a new trigger is accepted
            state_reg <= cfgrb_pkg::CFGRB_REINIT;
            read_in_progress <= 1'b0;
            readbackData <= 1'b1;
         end
         else
         begin
            case (state_reg)
               cfgrb_pkg::CFGRB_IDLE:
               begin
                  if (startPend_reg)
                  begin
                     state_reg <= cfgrb_pkg::CFGRB_DUMMY;
                     read_in_progress <= 1'b1;
                     bitCnt_reg <= '0;
                     frame_reg <= '0;
                     crc_reg <= cfgrb_pkg::CFGRB_CRC_INIT;
                  end
               end
               cfgrb_pkg::CFGRB_DUMMY:
               begin
                  readbackData <= 1'b1;
                  if (bitCnt_reg == '0)
                     stage_reg <= word0;
                  bitCnt_reg <= bitCnt_reg + BCW'(1);
                  if (bitCnt_reg == BCW'(cfgrb_pkg::CFGRB_DUMMY_BITS - 1))
                     state_reg <= cfgrb_pkg::CFGRB_START;
               end
               cfgrb_pkg::CFGRB_START:
               begin
                  readbackData <= 1'b0;
                  shift_reg <= stage_reg;
                  bitCnt_reg <= '0;
                  state_reg <= cfgrb_pkg::CFGRB_DATA;
               end
               cfgrb_pkg::CFGRB_DATA:
               begin
                  readbackData <= shift_reg[FRAME_W-1];
                  shift_reg <= {shift_reg[FRAME_W-2:0], 1'b0};
                  crc_reg <= crcStep(crc_reg, shift_reg[FRAME_W-1]);
                  bitCnt_reg <= bitCnt_reg + BCW'(1);
                  if (lastData)
                  begin
                     if (!lastFrame)
                        stage_reg <= wordNext;
                     bitCnt_reg <= '0;
                     state_reg <= cfgrb_pkg::CFGRB_CHECK;
                  end
               end
               cfgrb_pkg::CFGRB_CHECK:
               begin
                  readbackData <= 1'b1;
                  bitCnt_reg <= bitCnt_reg + BCW'(1);
                  if (lastCheck)
                  begin
                     if (lastFrame)
                        state_reg <= cfgrb_pkg::CFGRB_CRCST;
                     else
                     begin
                        frame_reg <= nextFrame;
                        state_reg <= cfgrb_pkg::CFGRB_START;
                     end
                  end
               end
               cfgrb_pkg::CFGRB_CRCST:
               begin
                  readbackData <= 1'b0;
                  crcOut_reg <= crc_reg;
                  crcLast_reg <= crc_reg;
                  bitCnt_reg <= '0;
                  state_reg <= cfgrb_pkg::CFGRB_CRC;
               end
               cfgrb_pkg::CFGRB_CRC:
               begin
                  readbackData <= crcOut_reg[CRCW-1];
                  crcOut_reg <= {crcOut_reg[CRCW-2:0], 1'b0};
                  bitCnt_reg <= bitCnt_reg + BCW'(1);
                  if (bitCnt_reg == BCW'(CRCW - 1))
                     state_reg <= cfgrb_pkg::CFGRB_REINIT;
               end
               cfgrb_pkg::CFGRB_REINIT:
               begin
                  // Flag drops one edge after the last signature bit
                  read_in_progress <= 1'b0;
                  readbackData <= 1'b1;
                  state_reg <= cfgrb_pkg::CFGRB_IDLE;
               end
               default:
               begin
                  state_reg <= cfgrb_pkg::CFGRB_IDLE;
                  read_in_progress <= 1'b0;
               end
            endcase
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
endmodule // cfgrb_readback_ctrl
`default_nettype wire

// ### verif/cfgrb_readback_checker.sv
// Purpose: Port-level assertions for the readback controller
// Assumes: Pins cross into clk_sys through two flops and an edge flop
// Notes: Clock ages let stream changes be tied to a link clock rise
`timescale 1ns/10ps
`default_nettype none
module cfgrb_readback_checker
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic configuration_clock,
   input wire logic userReadbackClock,
   input wire logic readbackData,
   input wire logic read_in_progress
);
   logic cfgQ, usrQ;
   logic [3:0] cfgAge, usrAge;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Cycles since each clock pin rose, saturating so it never wraps
   always_ff @(posedge clk_sys)
   begin
      cfgQ <= configuration_clock;
      usrQ <= userReadbackClock;
      cfgAge <= (reset || (configuration_clock && !cfgQ)) ? 4'h0 :
         ((&cfgAge) ? cfgAge : cfgAge + 4'h1);
      usrAge <= (reset || (userReadbackClock && !usrQ)) ? 4'h0 :
         ((&usrAge) ? usrAge : usrAge + 4'h1);
   end
   // Bus handshake
   a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      && clkEn |=> wb_ack_o) else $error("no ack after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_req: assert property ($rose(wb_ack_o) |->
      $past(wb_stb_i) && $past(wb_cyc_i)) else $error("ack without request");
   a_hole_reads_zero: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i >= 8'h18 |-> wb_dat_o == 32'h0) else $error("hole not zero");
   a_status_tracks: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == cfgrb_pkg::CFGRB_STATUS_OFS |->
      wb_dat_o[0] == $past(read_in_progress)) else $error("status flag off");
   // Serial stream
   a_idle_high: assert property (
      !read_in_progress && !$past(read_in_progress) |-> readbackData)
      else $error("data not high while idle");
   a_dummy_high: assert property (
      $rose(read_in_progress) |-> readbackData [*8])
      else $error("dummy bits not high");
   a_data_holds: assert property (
      $changed(readbackData) |=> $stable(readbackData) [*5])
      else $error("data moved twice in one link cycle");
   a_data_on_rise: assert property (
      $changed(readbackData) || $changed(read_in_progress) |->
      cfgAge < 4'h9 || usrAge < 4'h9) else $error("change without clock rise");
endmodule // cfgrb_readback_checker
bind cfgrb_readback_ctrl cfgrb_readback_checker chk (
   .clk_sys(clk_sys),
   .reset(reset),
   .clkEn(clkEn),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .configuration_clock(configuration_clock),
   .userReadbackClock(userReadbackClock),
   .readbackData(readbackData),
   .read_in_progress(read_in_progress)
);
`default_nettype wire

// ### verif/cfgrb_ctrl_model.sv
// Purpose: Outside controller driving trigger and readback clock
// Assumes: Bench calls run once per readback and waits for it
// Notes: Phases stretch to 300 ns around each start bit, else 80 ns
`timescale 1ns/10ps
`default_nettype none
module cfgrb_ctrl_model
#(
   parameter int FRAME_W = 32
)
(
   output var logic readback_trigger,
   output var logic rbClk,
   input wire logic readbackData,
   input wire logic read_in_progress
);
   localparam int L = FRAME_W + 5;
   logic bits [512];
   logic rips [512];
   // Clock stands still low between readbacks
   initial
   begin
      readback_trigger = 1'b0;
      rbClk = 1'b0;
   end
   // Clocking goes on after an abort so control logic re-initialises
   task automatic run(input int nRise, input int cut, input logic again,
      input int stall);
      int m;
      int ph;
      #7;
      readback_trigger = 1'b1;
      #300;
      for (int n = 0; n < nRise; n++)
      begin
         m = (n + L - 6) % L;
         ph = (n <= 6 || m == 0 || m > L - 6) ? 300 : 80;
         if (n == stall)
            #3000;
         if (n == cut || (again && n == cut + 2))
         begin
            readback_trigger = (n != cut);
            #300;
         end
         rbClk = 1'b1;
         #ph;
         rbClk = 1'b0;
         #(ph - 10);
         bits[n] = readbackData;
         rips[n] = read_in_progress;
         #10;
      end
      readback_trigger = 1'b0;
   endtask
endmodule // cfgrb_ctrl_model
`default_nettype wire

// ### verif/testbench.sv
// Purpose: Self-checking bench for the readback controller
// Assumes: Partner model drives trigger and the selected clock
// Notes: Frame width and count shortened by parameter
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int FW = 12;
   localparam int NF = 3;
   localparam int CF = 1;
   localparam int T = 1 + 5 + NF * (FW + 5) + 1 + 11 + 1;
   logic clk_sys, reset, cyc, stb, we, useUser, noiseClk, startupFinished;
   logic wbAck, rbData, rip, trig, rbClk;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, wbDatO;
   logic [FW-1:0] captureIn, expCapt;
   logic [FW-1:0] mem [NF];
   logic [10:0] expCrc;
   logic expBit [T];
   int mismatches, compares, wr;
   // System clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // The unselected clock line keeps toggling to prove it is ignored
   initial
   begin
      noiseClk = 1'b0;
      forever #100 noiseClk = ~noiseClk;
   end
   cfgrb_readback_ctrl #(.FRAME_W(FW), .NUM_FRAMES(NF), .CAPT_FRAME(CF)) uut (
      .clk_sys(clk_sys),
      .reset(reset),
      .clkEn(1'b1),
      .wb_cyc_i(cyc),
      .wb_stb_i(stb),
      .wb_we_i(we),
      .wb_adr_i(adr),
      .wb_sel_i(4'hf),
      .wb_dat_i(wdat),
      .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck),
      .readback_trigger(trig),
      .configuration_clock(useUser ? noiseClk : rbClk),
      .userReadbackClock(useUser ? rbClk : noiseClk),
      .startupFinished(startupFinished),
      .captureIn(captureIn),
      .readbackData(rbData),
      .read_in_progress(rip)
   );
   cfgrb_ctrl_model #(.FRAME_W(FW)) pm (
      .readback_trigger(trig),
      .rbClk(rbClk),
      .readbackData(rbData),
      .read_in_progress(rip)
   );
   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Classic single cycle; waits for ack under a bound
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1 && n < 64);
      q = wbDatO;
      cyc <= 1'b0;
      stb <= 1'b0;
      check(wbAck, 1'b1);
   endtask
   function automatic void put(input logic b);
      expBit[wr] = b;
      wr++;
   endfunction
   // Expected bit at each link rise, and the signature
   function automatic void build(input logic capt);
      logic [FW-1:0] w;
      logic fb;
      wr = 0;
      expCrc = cfgrb_pkg::CFGRB_CRC_INIT;
      repeat (6) put(1'b1);
      for (int f = 0; f < NF; f++)
      begin
         w = (capt && f == CF) ? expCapt : mem[f];
         if (f == 0)
            w[FW-1 -: 2] = 2'h3;
         if (f == NF - 1)
            w[6:0] = 7'h7f;
         put(1'b0);
         for (int b = FW - 1; b >= 0; b--)
         begin
            put(w[b]);
            fb = expCrc[10] ^ w[b];
            expCrc = {expCrc[9:0], 1'b0} ^
               (fb ? cfgrb_pkg::CFGRB_CRC_POLY : 11'h000);
         end
         repeat (4) put(1'b1);
      end
      put(1'b0);
      for (int b = 10; b >= 0; b--)
         put(expCrc[b]);
      put(1'b1);
   endfunction
   // One readback with given options, then stream and register checks
   task automatic do_run(input logic [2:0] ctrl, input int cut,
      input logic again, input int stall);
      logic [FW-1:0] cv;
      int lim;
      cv = FW'($urandom);
      lim = ctrl[0] ? cut : T;
      wb(1'b1, cfgrb_pkg::CFGRB_CTRL_OFS, {29'h0, ctrl}, rdat);
      @(posedge clk_sys);
      useUser <= ctrl[2];
      captureIn <= cv;
      expCapt = ~cv;
      build(ctrl[1]);
      pm.run(T + 1, cut, again, stall);
      for (int n = 0; n < T; n++)
      begin
         check(pm.bits[n], n < lim ? expBit[n] : 1'b1);
         check(pm.rips[n], n < lim && n < T - 1);
      end
      wb(1'b0, cfgrb_pkg::CFGRB_STATUS_OFS, 32'h0, rdat);
      check(rdat[0], 1'b0);
      wb(1'b0, cfgrb_pkg::CFGRB_CRC_OFS, 32'h0, rdat);
      if (lim == T)
         check(rdat, expCrc);
      wb(1'b0, cfgrb_pkg::CFGRB_CAPT_OFS, 32'h0, rdat);
      if (ctrl[1])
         check(rdat, expCapt);
   endtask
   // Main sequence
   initial
   begin
      int cut;
      {reset, cyc, stb, we, useUser, startupFinished} = 6'h20;
      {adr, wdat, captureIn, mismatches, compares, wr} = '0;
      void'($urandom(32'h2eeb067d));
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
      wb(1'b0, cfgrb_pkg::CFGRB_CTRL_OFS, 32'h0, rdat);
      check(rdat, {29'h0, cfgrb_pkg::CFGRB_CTRL_RESET});
      wb(1'b1, 8'h40, 32'hffffffff, rdat);
      wb(1'b0, 8'h40, 32'h0, rdat);
      check(rdat, 32'h0);
      for (int f = 0; f < NF; f++)
      begin
         mem[f] = FW'($urandom);
         wb(1'b1, cfgrb_pkg::CFGRB_FIDX_OFS, f, rdat);
         wb(1'b1, cfgrb_pkg::CFGRB_FDATA_OFS, mem[f], rdat);
         wb(1'b0, cfgrb_pkg::CFGRB_FDATA_OFS, 32'h0, rdat);
         check(rdat, mem[f]);
      end
      // Trigger held low so far: no readback may have begun
      check(rip, 1'b0);
      // Trigger already high when start-up finishes
      fork
         do_run(3'h0, T + 5, 1'b0, -1);
         begin
            repeat (14) @(posedge clk_sys);
            startupFinished <= 1'b1;
         end
      join
      do_run(3'h6, T + 5, 1'b0, 14);
      cut = 8 + $urandom % (FW - 3) + (FW + 5) * ($urandom % NF);
      do_run(3'h0, cut, 1'b1, -1);
      cut = 8 + $urandom % (FW - 3) + (FW + 5) * ($urandom % NF);
      do_run(3'h1, cut, 1'b0, -1);
      do_run(3'h3, T + 5, 1'b0, -1);
      wrap_up();
   end
   // Watchdog, about three times the expected run
   initial
   begin
      #400000;
      mismatches++;
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
